// *** fpd_pkg.sv ***
// Notes on behaviour
// - Config bit 5 clear enables the bus timeout; set disables it.
// - Config bit 4 clear: output low at full duty; set: output high.
// - Auto mode, config bit 3 clear: zero duty once temperature plus hysteresis is under start, start duty at it.
// - Config bit 3 set: start duty held below start threshold, rising above.
// - Config bit 2 set disables spin-up; clear allows spin-up from rest.
// - Alarm mask bit 7 blocks remote faults, bit 6 blocks local faults.
// - Start duty of 240 is full duty; larger values count as full.
// - Maximum duty caps automatic duty between 2 and 240; above 240 is full.
// - Manual mode ignores the maximum duty register.
// - Auto mode writes the computed target duty into the target register.
// - Nonzero ramp rate moves present duty toward target gradually.
// - Reading the present duty register returns the duty now on the output.
// - Remote and local start-temperature registers set each channel threshold.
// - Fan setup bit 7 picks hysteresis: 5 degrees clear, 10 degrees set.
// - Fan setup bit 6 picks temperature step: 1 degree clear, 2 set.
// - Fan setup bit 5 selects remote control, bit 4 selects local control.
// - Both source bits set: the higher of the two channel duties wins.
// - Both source bits clear: manual target drives duty, clipped to 240.
// - Ramp bits 7..5 set increment interval; increments are 2/240, also manual.
// - Ramp code 000 applies duty changes immediately.
// - Step bits 7..4 set duty change per temperature step.
// - Ramp codes give 0, 1/16, 1/8, 1/4, 1/2, 1, 2, 4 second intervals.
// - Step code N changes duty by 2N/240 per step; zero means no change.
// - Spin-up forces output on for 2 s; without it duty jumps at once.
package fpd_pkg;

  // Register offsets.
  localparam logic [7:0] ADDR_CONFIG     = 8'h02;
  localparam logic [7:0] ADDR_MASK       = 8'h06;
  localparam logic [7:0] ADDR_START_DUTY = 8'h07;
  localparam logic [7:0] ADDR_MAX_DUTY   = 8'h08;
  localparam logic [7:0] ADDR_TARGET     = 8'h09;
  localparam logic [7:0] ADDR_PRESENT    = 8'h0a;
  localparam logic [7:0] ADDR_REM_START  = 8'h0b;
  localparam logic [7:0] ADDR_LOC_START  = 8'h0c;
  localparam logic [7:0] ADDR_FAN_SETUP  = 8'h0d;
  localparam logic [7:0] ADDR_RAMP_RATE  = 8'h0e;
  localparam logic [7:0] ADDR_STEP_SIZE  = 8'h0f;

  // Reset values.
  localparam logic [7:0] RST_CONFIG     = 8'h00;
  localparam logic [7:0] RST_MASK       = 8'h00;
  localparam logic [7:0] RST_START_DUTY = 8'h60;
  localparam logic [7:0] RST_MAX_DUTY   = 8'hf0;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [7:0] RST_RAMP_RATE  = 8'ha0;
  localparam logic [7:0] RST_STEP_SIZE  = 8'h50;

  // Field positions.
  localparam int CFG_TIMEOUT_DIS = 5;
  localparam int CFG_INVERT      = 4;
  localparam int CFG_MIN_DUTY    = 3;
  localparam int CFG_SPIN_DIS    = 2;
  localparam int MASK_REMOTE     = 7;
  localparam int MASK_LOCAL      = 6;
  localparam int SETUP_HYST      = 7;
  localparam int SETUP_TSTEP     = 6;
  localparam int SETUP_REMOTE    = 5;
  localparam int SETUP_LOCAL     = 4;

  // Duty scale: 240 counts make a full period.
  localparam logic [7:0] DUTY_FULL  = 8'hf0;
  localparam logic [7:0] DUTY_FLOOR = 8'h02;
  localparam logic [7:0] DUTY_INC   = 8'h02;
  localparam logic [7:0] HYST_LO    = 8'h05;
  localparam logic [7:0] HYST_HI    = 8'h0a;

  // Timing.
  localparam int CLK_MHZ       = 100;
  localparam int RAMP_BASE_US  = 62500;
  localparam int RAMP_BASE_CYC = RAMP_BASE_US * CLK_MHZ;
  localparam int SPINUP_MS     = 2000;
  localparam int SPINUP_CYC    = SPINUP_MS * 1000 * CLK_MHZ;
  localparam int PWM_HZ        = 33;
  localparam int PWM_TICK_CYC  = (CLK_MHZ * 1000000) / (PWM_HZ * 240);

  // Output drive state.
  typedef enum logic [0:0] {
    FPD_RUN  = 1'b0,
    FPD_SPIN = 1'b1
  } fpd_mode_t;

endpackage

// *** fpd_fan_pwm.sv ***
`timescale 1ns/1ps
module fpd_fan_pwm #(
  parameter int RAMP_CYC  = fpd_pkg::RAMP_BASE_CYC,
  parameter int SPIN_CYC  = fpd_pkg::SPINUP_CYC,
  parameter int TICK_CYC  = fpd_pkg::PWM_TICK_CYC
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register port behind the serial-bus engine.
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Temperature readings and channel faults.
  input  wire logic [7:0] remote_temp,
  input  wire logic [7:0] local_temp,
  input  wire logic       remote_fault,
  input  wire logic       local_fault,
  // Bus engine control.
  output logic            bus_timeout_en,
  // Fan drive pin, open drain.
  input  wire logic       fan_drive_in,
  output logic            fan_drive_out,
  output logic            fan_drive_oe,
  // Over-temperature pin, open drain, active low.
  input  wire logic       overtemp_alarm_n_in,
  output logic            overtemp_alarm_n,
  output logic            overtemp_alarm_n_oe
);
  import fpd_pkg::*;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  mask;
    logic [7:0]  start_duty;
    logic [7:0]  max_duty;
    logic [7:0]  target;
    logic [7:0]  present;
    logic [7:0]  rem_start;
    logic [7:0]  loc_start;
    logic [7:0]  setup;
    logic [7:0]  rate;
    logic [7:0]  step;
    logic        rem_on;
    logic        loc_on;
    fpd_mode_t   mode;
    logic [31:0] ramp_cnt;
    logic [31:0] spin_cnt;
    logic [31:0] tick_cnt;
    logic [7:0]  slot;
    logic [7:0]  rdata;
    logic        tmo_en;
    logic        fan_lvl;
    logic        fan_oe;
    logic        alarm_n;
    logic        alarm_oe;
  } fpd_state_t;

  fpd_state_t st;
  fpd_state_t next_st;

  // Clip a duty value to the full-scale count.
  function automatic logic [7:0] fpd_clip(input logic [7:0] v);
    fpd_clip = (v > DUTY_FULL) ? DUTY_FULL : v;
  endfunction

  // Duty for one channel from its reading, threshold and engaged flag.
  function automatic logic [7:0] fpd_chan_duty(
    input logic [7:0] temp,
    input logic [7:0] start,
    input logic       on,
    input logic       min_hold,
    input logic       two_deg,
    input logic [3:0] step_code,
    input logic [7:0] sduty,
    input logic [7:0] mduty
  );
    logic [7:0]  steps;
    logic [15:0] sum;
    logic [7:0]  duty;
    steps = 8'h00;
    sum   = 16'h0000;
    duty  = 8'h00;
    if (temp >= start)
    begin
      steps = two_deg ? ((temp - start) >> 1) : (temp - start);
      sum = {8'h00, sduty} + 16'(steps) * 16'({step_code, 1'b0});
      duty = (sum > 16'(DUTY_FULL)) ? DUTY_FULL : sum[7:0];
    end
    else if (on || min_hold)
      duty = sduty;
    else
      duty = 8'h00;
    fpd_chan_duty = (duty > mduty) ? mduty : duty;
  endfunction

  // Channel engage flag with hysteresis below the threshold.
  function automatic logic fpd_engage(
    input logic [7:0] temp,
    input logic [7:0] start,
    input logic [7:0] hyst,
    input logic       on
  );
    if (temp >= start)
      fpd_engage = 1'b1;
    else if ({1'b0, temp} + {1'b0, hyst} < {1'b0, start})
      fpd_engage = 1'b0;
    else
      fpd_engage = on;
  endfunction

  logic       auto_mode;
  logic [7:0] sduty_lim;
  logic [7:0] mduty_lim;
  logic [7:0] hyst;
  logic [7:0] rem_duty;
  logic [7:0] loc_duty;
  logic [7:0] auto_duty;
  logic [7:0] goal;
  logic [7:0] view_duty;
  logic [31:0] interval;
  logic       active;

  // Control law: channel duties, source selection and clipping.
  always_comb
  begin
    auto_mode = st.setup[SETUP_REMOTE] | st.setup[SETUP_LOCAL];
    sduty_lim = fpd_clip(st.start_duty);
    mduty_lim = fpd_clip(st.max_duty);
    if (mduty_lim < DUTY_FLOOR)
      mduty_lim = DUTY_FLOOR;
    hyst = st.setup[SETUP_HYST] ? HYST_HI : HYST_LO;
    rem_duty = fpd_chan_duty(remote_temp, st.rem_start, st.rem_on, st.cfg[CFG_MIN_DUTY],
                             st.setup[SETUP_TSTEP], st.step[7:4], sduty_lim,
                             mduty_lim);
    loc_duty = fpd_chan_duty(local_temp, st.loc_start, st.loc_on, st.cfg[CFG_MIN_DUTY],
                             st.setup[SETUP_TSTEP], st.step[7:4], sduty_lim,
                             mduty_lim);
    if (st.setup[SETUP_REMOTE] && st.setup[SETUP_LOCAL])
      auto_duty = (rem_duty > loc_duty) ? rem_duty : loc_duty;
    else if (st.setup[SETUP_REMOTE])
      auto_duty = rem_duty;
    else
      auto_duty = loc_duty;
    // Manual goal bypasses the maximum register entirely.
    goal = auto_mode ? st.target : fpd_clip(st.target);
    view_duty = (st.mode == FPD_SPIN) ? DUTY_FULL : st.present;
    interval = (st.rate[7:5] == 3'b000) ? 32'd1 :
               (32'(RAMP_CYC) << (st.rate[7:5] - 3'b001));
    active = st.slot < view_duty;
  end

  // Next state: register writes, ramp, spin-up, pulse generator, pins.
  always_comb
  begin
    next_st = st;
    if (reg_wr)
    begin
      case (reg_addr)
        ADDR_CONFIG:     next_st.cfg = reg_wdata;
        ADDR_MASK:       next_st.mask = reg_wdata;
        ADDR_START_DUTY: next_st.start_duty = reg_wdata;
        ADDR_MAX_DUTY:   next_st.max_duty = reg_wdata;
        ADDR_TARGET:     next_st.target = reg_wdata;
        ADDR_REM_START:  next_st.rem_start = reg_wdata;
        ADDR_LOC_START:  next_st.loc_start = reg_wdata;
        ADDR_FAN_SETUP:  next_st.setup = reg_wdata;
        ADDR_RAMP_RATE:  next_st.rate = reg_wdata;
        ADDR_STEP_SIZE:  next_st.step = reg_wdata;
        default:         next_st.cfg = st.cfg;
      endcase
    end
    // In automatic mode the computed target overrides any host write.
    if (auto_mode)
      next_st.target = auto_duty;
    next_st.rem_on = fpd_engage(remote_temp, st.rem_start, hyst, st.rem_on);
    next_st.loc_on = fpd_engage(local_temp, st.loc_start, hyst, st.loc_on);

    // Read port; unmapped offsets read as zero.
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_CONFIG:     next_st.rdata = st.cfg;
        ADDR_MASK:       next_st.rdata = st.mask;
        ADDR_START_DUTY: next_st.rdata = st.start_duty;
        ADDR_MAX_DUTY:   next_st.rdata = st.max_duty;
        ADDR_TARGET:     next_st.rdata = st.target;
        ADDR_PRESENT:    next_st.rdata = view_duty;
        ADDR_REM_START:  next_st.rdata = st.rem_start;
        ADDR_LOC_START:  next_st.rdata = st.loc_start;
        ADDR_FAN_SETUP:  next_st.rdata = st.setup;
        ADDR_RAMP_RATE:  next_st.rdata = st.rate;
        ADDR_STEP_SIZE:  next_st.rdata = st.step;
        default:         next_st.rdata = 8'h00;
      endcase
    end

    // Duty movement. A stalled fan needs a full kick before any ramp.
    case (st.mode)
      FPD_RUN:
      begin
        if (st.present == 8'h00 && goal != 8'h00)
        begin
          next_st.ramp_cnt = 32'd0;
          if (st.cfg[CFG_SPIN_DIS])
            next_st.present = goal;
          else
          begin
            next_st.mode = FPD_SPIN;
            next_st.spin_cnt = 32'd0;
          end
        end
        else if (st.rate[7:5] == 3'b000 || st.present == goal)
        begin
          next_st.present = goal;
          next_st.ramp_cnt = 32'd0;
        end
        else if (st.ramp_cnt >= interval - 32'd1)
        begin
          next_st.ramp_cnt = 32'd0;
          // Each increment is two counts; a smaller gap closes exactly.
          if (goal > st.present)
            next_st.present = (goal - st.present > DUTY_INC) ?
                              st.present + DUTY_INC : goal;
          else
            next_st.present = (st.present - goal > DUTY_INC) ?
                              st.present - DUTY_INC : goal;
        end
        else
          next_st.ramp_cnt = st.ramp_cnt + 32'd1;
      end
      FPD_SPIN:
      begin
        if (goal == 8'h00)
          next_st.mode = FPD_RUN;
        else if (st.spin_cnt >= 32'(SPIN_CYC) - 32'd1)
        begin
          next_st.mode = FPD_RUN;
          next_st.present = goal;
        end
        else
          next_st.spin_cnt = st.spin_cnt + 32'd1;
      end
      default:
        next_st.mode = FPD_RUN;
    endcase

    // Period of 240 slots, each slot TICK_CYC clocks long.
    if (st.tick_cnt >= 32'(TICK_CYC) - 32'd1)
    begin
      next_st.tick_cnt = 32'd0;
      next_st.slot = (st.slot >= DUTY_FULL - 8'h01) ? 8'h00 : st.slot + 8'h01;
    end
    else
      next_st.tick_cnt = st.tick_cnt + 32'd1;

    // Pin levels. The pin is pulled low only when the wanted level is low.
    next_st.fan_lvl = active ? st.cfg[CFG_INVERT] : ~st.cfg[CFG_INVERT];
    next_st.fan_oe = ~next_st.fan_lvl;
    next_st.alarm_oe = (remote_fault & ~st.mask[MASK_REMOTE]) |
                       (local_fault & ~st.mask[MASK_LOCAL]);
    next_st.alarm_n = ~next_st.alarm_oe;
    next_st.tmo_en = ~st.cfg[CFG_TIMEOUT_DIS];
  end

  // State register.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.cfg <= RST_CONFIG;
      st.mask <= RST_MASK;
      st.start_duty <= RST_START_DUTY;
      st.max_duty <= RST_MAX_DUTY;
      st.target <= RST_ZERO;
      st.present <= RST_ZERO;
      st.rem_start <= RST_ZERO;
      st.loc_start <= RST_ZERO;
      st.setup <= RST_ZERO;
      st.rate <= RST_RAMP_RATE;
      st.step <= RST_STEP_SIZE;
      st.mode <= FPD_RUN;
      st.tmo_en <= 1'b1;
      st.alarm_n <= 1'b1;
      st.fan_lvl <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state register.
  assign reg_rdata = st.rdata;
  assign bus_timeout_en = st.tmo_en;
  assign fan_drive_out = st.fan_lvl;
  assign fan_drive_oe = st.fan_oe;
  assign overtemp_alarm_n = st.alarm_n;
  assign overtemp_alarm_n_oe = st.alarm_oe;

  // Checks on the control law. Every output is a flip-flop, so most checks look one
  // cycle after the cause and compare against the state sampled at the cause.
  timeout_ctrl_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ##1 bus_timeout_en == !$past(st.cfg[CFG_TIMEOUT_DIS]))
    else $error("bus timeout enable does not follow config bit");

  full_polarity_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.mode == FPD_SPIN) |=> fan_drive_oe == !$past(st.cfg[CFG_INVERT]))
    else $error("output level wrong at full duty");

  alarm_mask_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.mask[MASK_REMOTE] && st.mask[MASK_LOCAL]) |=> !overtemp_alarm_n_oe)
    else $error("masked fault reached the alarm pin");

  alarm_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (remote_fault && !st.mask[MASK_REMOTE]) |=> overtemp_alarm_n_oe && !overtemp_alarm_n)
    else $error("unmasked remote fault did not assert alarm");

  manual_clip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!auto_mode && st.mode == FPD_RUN && st.rate[7:5] == 3'b000 && st.present != 8'h00)
    |=> st.present == (($past(st.target) > DUTY_FULL) ? DUTY_FULL : $past(st.target)))
    else $error("manual duty not applied or not clipped");

  auto_cap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    auto_mode |=> st.target <= (($past(st.max_duty) < DUTY_FLOOR) ? DUTY_FLOOR :
                                ($past(st.max_duty) > DUTY_FULL) ? DUTY_FULL :
                                $past(st.max_duty)))
    else $error("automatic target above maximum duty");

  ramp_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.mode == FPD_RUN && st.rate[7:5] != 3'b000 && st.present != 8'h00)
    |=> (st.present <= $past(st.present) + DUTY_INC) &&
        (st.present + DUTY_INC >= $past(st.present)))
    else $error("ramp moved more than one increment");

  spin_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.mode == FPD_RUN && st.present == 8'h00 && goal != 8'h00 &&
     !st.cfg[CFG_SPIN_DIS]) |=> st.mode == FPD_SPIN ##1
    (st.mode == FPD_SPIN || $past(goal) == 8'h00))
    else $error("spin-up not entered from rest");

  spin_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.mode == FPD_RUN && st.present == 8'h00 && goal != 8'h00 &&
     st.cfg[CFG_SPIN_DIS]) |=> st.present == $past(goal) && st.mode == FPD_RUN)
    else $error("duty did not jump with spin-up disabled");

  present_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == ADDR_PRESENT) |=> reg_rdata == $past(view_duty))
    else $error("present duty read mismatch");

  both_max_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.setup[SETUP_REMOTE] && st.setup[SETUP_LOCAL])
    |=> (st.target >= $past(rem_duty)) && (st.target >= $past(loc_duty)))
    else $error("combined mode did not take the higher channel duty");

  manual_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!auto_mode && !(reg_wr && reg_addr == ADDR_TARGET)) |=> st.target == $past(st.target))
    else $error("manual target changed without a host write");

  ramp_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st.mode == FPD_RUN && st.rate[7:5] != 3'b000 && st.present != 8'h00 &&
     st.ramp_cnt < interval - 32'd1) |=> st.present == $past(st.present))
    else $error("duty moved before the ramp interval ran out");

  local_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (local_fault && !st.mask[MASK_LOCAL]) |=> overtemp_alarm_n_oe && !overtemp_alarm_n)
    else $error("unmasked local fault did not assert alarm");

  alarm_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!remote_fault && !local_fault) |=> !overtemp_alarm_n_oe && overtemp_alarm_n)
    else $error("alarm asserted with no fault present");

endmodule

// *** fpd_fan_model.sv ***
`timescale 1ns/1ps
module fpd_fan_model #(
  parameter int PERIOD = 240
) (
  // Clock and reset.
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Resolved drive pin after the pull-up.
  input  wire logic       fan_pin,
  // Pin-high clocks seen over the last full window.
  output logic      [7:0] high_count
);
  logic [7:0] win_cnt;
  logic [7:0] acc;

  // The fan only responds to the averaged drive, so count high clocks per period.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      win_cnt    <= 8'h00;
      acc        <= 8'h00;
      high_count <= 8'h00;
    end
    else if (win_cnt == 8'(PERIOD - 1))
    begin
      high_count <= acc + 8'(fan_pin);
      acc        <= 8'h00;
      win_cnt    <= 8'h00;
    end
    else
    begin
      acc     <= acc + 8'(fan_pin);
      win_cnt <= win_cnt + 8'h01;
    end
  end

endmodule

// *** fpd_fan_pwm_tb.sv ***
`timescale 1ns/1ps
module fpd_fan_pwm_tb;
  import fpd_pkg::*;
  // Clock, reset and register port.
  logic       clk_sys      = 1'b0;
  logic       rst_n        = 1'b0;
  logic       reg_wr       = 1'b0;
  logic       reg_rd       = 1'b0;
  logic [7:0] reg_addr     = 8'h00;
  logic [7:0] reg_wdata    = 8'h00;
  logic [7:0] reg_rdata;
  // Temperatures and faults.
  logic [7:0] remote_temp  = 8'h00;
  logic [7:0] local_temp   = 8'h00;
  logic       remote_fault = 1'b0;
  logic       local_fault  = 1'b0;
  // Outputs, resolved pins and bookkeeping.
  logic       bus_timeout_en;
  logic       fan_drive_out;
  logic       fan_drive_oe;
  logic       overtemp_alarm_n;
  logic       overtemp_alarm_n_oe;
  logic       fan_pin;
  logic       alarm_pin;
  logic [7:0] high_count;
  int         fail_count   = 0;
  int         checked      = 0;

  // Both pins are open drain with pull-ups, so a released pin reads high.
  assign fan_pin   = fan_drive_oe ? 1'b0 : 1'b1;
  assign alarm_pin = overtemp_alarm_n_oe ? 1'b0 : 1'b1;

  // Clock generator.
  always #5 clk_sys = ~clk_sys;

  // Short counts keep ramp and spin-up inside a quick run.
  fpd_fan_pwm #(.RAMP_CYC(8), .SPIN_CYC(20), .TICK_CYC(1)) u_dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .remote_temp(remote_temp),
    .local_temp(local_temp),
    .remote_fault(remote_fault),
    .local_fault(local_fault),
    .bus_timeout_en(bus_timeout_en),
    .fan_drive_in(fan_pin),
    .fan_drive_out(fan_drive_out),
    .fan_drive_oe(fan_drive_oe),
    .overtemp_alarm_n_in(alarm_pin),
    .overtemp_alarm_n(overtemp_alarm_n),
    .overtemp_alarm_n_oe(overtemp_alarm_n_oe)
  );

  // The fan behind the drive pin.
  fpd_fan_model u_fan (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .fan_pin(fan_pin),
    .high_count(high_count)
  );

  task automatic end_sim();
    $display("Counts: %0d compared, %0d mismatched", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_sys);
    reg_wr    = 1'b1;
    reg_addr  = addr;
    reg_wdata = data;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask

  // Read data lands one edge after the strobe and holds, so sample a cycle later.
  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk_sys);
    reg_rd   = 1'b1;
    reg_addr = addr;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    data = reg_rdata;
  endtask

  task automatic chk_reg(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(addr, d);
    chk_byte(d, exp);
  endtask

  // Sets both temperatures, lets the target settle, then checks it.
  task automatic auto_step(input logic [7:0] rt, input logic [7:0] lt, input logic [7:0] exp);
    @(negedge clk_sys);
    remote_temp = rt;
    local_temp  = lt;
    wait_cyc(4);
    chk_reg(ADDR_TARGET, exp);
  endtask

  task automatic test_reset();
    logic [7:0] addrs [11] = '{ADDR_CONFIG, ADDR_MASK, ADDR_START_DUTY, ADDR_MAX_DUTY,
      ADDR_TARGET, ADDR_PRESENT, ADDR_REM_START, ADDR_LOC_START, ADDR_FAN_SETUP,
      ADDR_RAMP_RATE, ADDR_STEP_SIZE};
    logic [7:0] vals [11] = '{8'h00, 8'h00, 8'h60, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'ha0, 8'h50};
    foreach (addrs[i])
      chk_reg(addrs[i], vals[i]);
    chk_reg(8'h10, 8'h00);
    reg_write(ADDR_PRESENT, 8'h55);
    chk_reg(ADDR_PRESENT, 8'h00);
    chk_bit(bus_timeout_en, 1'b1);
    reg_write(ADDR_CONFIG, 8'h20);
    wait_cyc(2);
    chk_bit(bus_timeout_en, 1'b0);
    reg_write(ADDR_CONFIG, 8'h00);
    wait_cyc(2);
    chk_bit(bus_timeout_en, 1'b1);
    $display("Test reset and config done");
  endtask

  task automatic set_faults(input logic rf, input logic lf, input logic [7:0] mask);
    reg_write(ADDR_MASK, mask);
    remote_fault = rf;
    local_fault  = lf;
    wait_cyc(3);
  endtask

  task automatic test_alarm();
    set_faults(1'b1, 1'b0, 8'h00);
    chk_bit(alarm_pin, 1'b0);
    chk_bit(overtemp_alarm_n, 1'b0);
    set_faults(1'b1, 1'b0, 8'h80);
    chk_bit(alarm_pin, 1'b1);
    chk_bit(overtemp_alarm_n, 1'b1);
    set_faults(1'b0, 1'b1, 8'h80);
    chk_bit(alarm_pin, 1'b0);
    set_faults(1'b0, 1'b1, 8'h40);
    chk_bit(alarm_pin, 1'b1);
    set_faults(1'b0, 1'b0, 8'h00);
    $display("Test alarm done");
  endtask

  task automatic test_manual();
    reg_write(ADDR_CONFIG, 8'h04);
    reg_write(ADDR_RAMP_RATE, 8'h00);
    reg_write(ADDR_MAX_DUTY, 8'h10);
    reg_write(ADDR_TARGET, 8'h30);
    chk_reg(ADDR_PRESENT, 8'h30);
    wait_cyc(500);
    chk_byte(high_count, 8'hc0);
    reg_write(ADDR_CONFIG, 8'h14);
    wait_cyc(500);
    chk_byte(high_count, 8'h30);
    reg_write(ADDR_TARGET, 8'hff);
    chk_reg(ADDR_PRESENT, 8'hf0);
    wait_cyc(500);
    chk_byte(high_count, 8'hf0);
    reg_write(ADDR_CONFIG, 8'h04);
    wait_cyc(500);
    chk_byte(high_count, 8'h00);
    reg_write(ADDR_MAX_DUTY, 8'hf0);
    $display("Test manual done");
  endtask

  task automatic test_spinup();
    reg_write(ADDR_TARGET, 8'h00);
    chk_reg(ADDR_PRESENT, 8'h00);
    reg_write(ADDR_CONFIG, 8'h10);
    reg_write(ADDR_TARGET, 8'h30);
    chk_reg(ADDR_PRESENT, 8'hf0);
    chk_bit(fan_pin, 1'b1);
    chk_bit(fan_drive_out, 1'b1);
    wait_cyc(30);
    chk_reg(ADDR_PRESENT, 8'h30);
    $display("Test spin-up done");
  endtask

  task automatic test_ramp();
    logic [7:0] p;
    reg_write(ADDR_CONFIG, 8'h14);
    reg_write(ADDR_TARGET, 8'h10);
    wait_cyc(4);
    reg_write(ADDR_RAMP_RATE, 8'h60);
    reg_write(ADDR_TARGET, 8'h20);
    reg_read(ADDR_PRESENT, p);
    chk_bit(p < 8'h20, 1'b1);
    wait_cyc(100);
    reg_read(ADDR_PRESENT, p);
    chk_bit((p > 8'h10) && (p < 8'h20), 1'b1);
    wait_cyc(300);
    chk_reg(ADDR_PRESENT, 8'h20);
    reg_write(ADDR_TARGET, 8'h18);
    wait_cyc(40);
    reg_read(ADDR_PRESENT, p);
    chk_bit((p > 8'h18) && (p < 8'h20), 1'b1);
    wait_cyc(200);
    chk_reg(ADDR_PRESENT, 8'h18);
    reg_write(ADDR_RAMP_RATE, 8'h00);
    $display("Test ramp done");
  endtask

  task automatic test_auto();
    reg_write(ADDR_CONFIG, 8'h04);
    reg_write(ADDR_REM_START, 8'h28);
    reg_write(ADDR_LOC_START, 8'h28);
    reg_write(ADDR_FAN_SETUP, 8'h20);
    auto_step(8'h28, 8'h00, 8'h60);
    auto_step(8'h2a, 8'h00, 8'h74);
    chk_reg(ADDR_PRESENT, 8'h74);
    reg_write(ADDR_STEP_SIZE, 8'h00);
    auto_step(8'h2a, 8'h00, 8'h60);
    reg_write(ADDR_STEP_SIZE, 8'h50);
    reg_write(ADDR_MAX_DUTY, 8'h70);
    auto_step(8'h2a, 8'h00, 8'h70);
    reg_write(ADDR_MAX_DUTY, 8'hff);
    auto_step(8'h2a, 8'h00, 8'h74);
    reg_write(ADDR_MAX_DUTY, 8'h00);
    auto_step(8'h2a, 8'h00, 8'h02);
    reg_write(ADDR_MAX_DUTY, 8'hf0);
    reg_write(ADDR_START_DUTY, 8'hf8);
    auto_step(8'h2a, 8'h00, 8'hf0);
    reg_write(ADDR_START_DUTY, 8'h60);
    reg_write(ADDR_FAN_SETUP, 8'h60);
    auto_step(8'h2a, 8'h00, 8'h6a);
    reg_write(ADDR_FAN_SETUP, 8'h20);
    auto_step(8'h24, 8'h00, 8'h60);
    auto_step(8'h22, 8'h00, 8'h00);
    reg_write(ADDR_FAN_SETUP, 8'ha0);
    auto_step(8'h28, 8'h00, 8'h60);
    auto_step(8'h20, 8'h00, 8'h60);
    auto_step(8'h1d, 8'h00, 8'h00);
    reg_write(ADDR_CONFIG, 8'h0c);
    auto_step(8'h10, 8'h00, 8'h60);
    reg_write(ADDR_CONFIG, 8'h04);
    reg_write(ADDR_FAN_SETUP, 8'h10);
    auto_step(8'h10, 8'h2c, 8'h88);
    reg_write(ADDR_FAN_SETUP, 8'h30);
    auto_step(8'h2a, 8'h2c, 8'h88);
    auto_step(8'h2a, 8'h20, 8'h74);
    $display("Test automatic done");
  endtask

  // Main sequence.
  initial
  begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    test_reset();
    test_alarm();
    test_manual();
    test_spinup();
    test_ramp();
    test_auto();
    end_sim();
  end

  // Watchdog sized well above the roughly three thousand cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_sim();
  end

endmodule
